/* File: design/doze_pkg.sv */
`default_nettype none
package doze_pkg;
	// register addresses on the plain register port
	localparam logic [3:0] addr_regulator = 4'h0;
	localparam logic [3:0] addr_speed = 4'h1;
	localparam logic [3:0] addr_status = 4'h2;
	// regulator register fields
	localparam int reg_pm_bit = 1;
	localparam int reg_one_bit = 0;
	// speed register fields
	localparam int spd_idle_bit = 7;
	localparam int spd_slow_bit = 6;
	localparam int spd_roi_bit = 5;
	localparam int spd_doe_bit = 4;
	localparam int spd_rsv_bit = 3;
	localparam int ratio_w = 3;
	// reset values
	localparam logic [7:0] reg_reset = 8'h01;
	localparam logic [7:0] spd_reset = 8'h00;
	// doze counter width: up to 256 peripheral cycles
	localparam int dcnt_w = 8;
	// wake settle delays in ns and cycles at 50 MHz
	localparam int clk_ns = 20;
	localparam int wake_fast_ns = 100;
	localparam int wake_lp_ns = 2000;
	localparam int wake_fast_cyc = (wake_fast_ns + clk_ns - 1) / clk_ns;
	localparam int wake_lp_cyc = (wake_lp_ns + clk_ns - 1) / clk_ns;
	localparam int wcnt_w = 8;
	// power state of the core
	typedef enum logic [1:0] {
		pwr_run = 2'b00,
		pwr_idle = 2'b01,
		pwr_sleep = 2'b10,
		pwr_wake = 2'b11
	} pwr_state_t;
	// core events into the block
	typedef struct packed {
		logic sleep_exec;
		logic isr_entry;
		logic isr_return;
		logic debug_active;
		logic wdt_timeout;
		logic irq_pending;
	} core_evt_t;
	// clock enables, regulator and watchdog controls out of the block
	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic regulator_low_power;
		logic wdt_reset_block;
	} clk_ctl_t;
endpackage : doze_pkg
`default_nettype wire

/* File: design/doze_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// produces one cpu enable pulse per 2^(ratio+1) cycles while active
module doze_divider (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic active,
	input wire logic [doze_pkg::ratio_w-1:0] ratio,
	output logic pulse
);
	logic [doze_pkg::dcnt_w-1:0] cnt_r; // cycle counter
	logic [doze_pkg::dcnt_w-1:0] limit; // terminal count
	logic [doze_pkg::ratio_w-1:0] ratio_r; // last ratio seen
	logic active_r; // last active seen
	logic restart; // settings changed
	// terminal count 2^(ratio+1)-1
	assign limit = doze_pkg::dcnt_w'((9'h002 << ratio) - 9'h001);
	assign restart = (ratio != ratio_r) || (active != active_r);
	assign pulse = active && (cnt_r == limit) && !restart;
	// counter restarts on change
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
			ratio_r <= 3'h0;
			active_r <= 1'b0;
		end else begin
			ratio_r <= ratio;
			active_r <= active;
			if (restart || cnt_r == limit) begin
				cnt_r <= 8'h00;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule : doze_divider
`default_nettype wire

/* File: design/doze_idle_control.sv */
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module doze_idle_control (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic por_bor_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire doze_pkg::core_evt_t core_evt,
	output var doze_pkg::clk_ctl_t clk_ctl
);
	logic pm_r; // regulator low-power select
	logic idle_sel_r; // idle on sleep select
	logic slow_r; // cpu slowdown active
	logic roi_r; // recover on interrupt
	logic doe_r; // slow on return
	logic [doze_pkg::ratio_w-1:0] ratio_r; // doze ratio code
	doze_pkg::pwr_state_t state_r; // power state
	doze_pkg::pwr_state_t state_nxt;
	logic [doze_pkg::wcnt_w-1:0] wcnt_r; // wake settle count
	logic doze_pulse; // divider pulse
	logic wr_spd; // software write to speed register
	logic wake_evt; // wake from sleep or idle
	logic cpu_en_nxt; // next cpu enable
	logic [7:0] rd_nxt; // read mux

	assign wr_spd = wr_stb && (addr == doze_pkg::addr_speed);
	// interrupt or watchdog both wake; neither resets
	assign wake_evt = core_evt.irq_pending || core_evt.wdt_timeout;

	// regulator register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pm_r <= doze_pkg::reg_reset[doze_pkg::reg_pm_bit];
		end else if (wr_stb && addr == doze_pkg::addr_regulator) begin
			pm_r <= wdata[doze_pkg::reg_pm_bit];
		end
	end

	// idle select: kept through warm reset, cleared by por/bor
	always_ff @(posedge sys_clk or negedge por_bor_n) begin
		if (!por_bor_n) begin
			idle_sel_r <= 1'b0;
		end else if (wr_spd) begin
			idle_sel_r <= wdata[doze_pkg::spd_idle_bit];
		end
	end

	// control bits cleared by general reset (reset_n)
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			roi_r <= 1'b0;
			doe_r <= 1'b0;
			ratio_r <= 3'h0;
		end else if (wr_spd) begin
			roi_r <= wdata[doze_pkg::spd_roi_bit];
			doe_r <= wdata[doze_pkg::spd_doe_bit];
			ratio_r <= wdata[doze_pkg::ratio_w-1:0];
		end
	end

	// slowdown bit: hardware events beat software writes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			slow_r <= 1'b0;
		end else if (core_evt.isr_entry && roi_r) begin
			slow_r <= 1'b0;
		end else if (core_evt.isr_return && doe_r) begin
			slow_r <= 1'b1;
		end else if (wr_spd) begin
			slow_r <= wdata[doze_pkg::spd_slow_bit];
		end
	end

	// cycle divider for doze
	doze_divider u_div (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.active(slow_r && !core_evt.debug_active),
		.ratio(ratio_r),
		.pulse(doze_pulse)
	);

	// power state sequencing
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			doze_pkg::pwr_run: begin
				if (core_evt.sleep_exec && idle_sel_r) begin
					state_nxt = doze_pkg::pwr_idle;
				end else if (core_evt.sleep_exec) begin
					state_nxt = doze_pkg::pwr_sleep;
				end
			end
			doze_pkg::pwr_idle: begin
				if (wake_evt) begin
					state_nxt = doze_pkg::pwr_run;
				end
			end
			doze_pkg::pwr_sleep: begin
				if (wake_evt) begin
					state_nxt = doze_pkg::pwr_wake;
				end
			end
			doze_pkg::pwr_wake: begin
				if (wcnt_r == 8'h00) begin
					state_nxt = doze_pkg::pwr_run;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= doze_pkg::pwr_run;
		end else begin
			state_r <= state_nxt;
		end
	end

	// wake settle counter, longer in low-power mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wcnt_r <= 8'h00;
		end else if (state_r == doze_pkg::pwr_sleep) begin
			wcnt_r <= pm_r ? 8'(doze_pkg::wake_lp_cyc - 1)
				: 8'(doze_pkg::wake_fast_cyc - 1);
		end else if (wcnt_r != 8'h00) begin
			wcnt_r <= wcnt_r - 8'h01;
		end
	end

	// cpu enable: debug forces full speed, slowdown gates
	always_comb begin
		if (state_nxt != doze_pkg::pwr_run) begin
			cpu_en_nxt = 1'b0;
		end else if (core_evt.debug_active || !slow_r) begin
			cpu_en_nxt = 1'b1;
		end else begin
			cpu_en_nxt = doze_pulse;
		end
	end

	// clock control outputs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_ctl <= '0;
		end else begin
			clk_ctl.cpu_clk_en <= cpu_en_nxt;
			clk_ctl.periph_clk_en <= (state_nxt != doze_pkg::pwr_sleep)
				&& (state_nxt != doze_pkg::pwr_wake);
			clk_ctl.regulator_low_power <= pm_r
				&& (state_nxt == doze_pkg::pwr_sleep);
			clk_ctl.wdt_reset_block <= (state_nxt == doze_pkg::pwr_idle)
				|| (state_nxt == doze_pkg::pwr_sleep);
		end
	end

	// read mux
	always_comb begin
		rd_nxt = 8'h00;
		if (addr == doze_pkg::addr_regulator) begin
			rd_nxt[doze_pkg::reg_pm_bit] = pm_r;
			rd_nxt[doze_pkg::reg_one_bit] = 1'b1;
		end else if (addr == doze_pkg::addr_speed) begin
			rd_nxt = {idle_sel_r, slow_r, roi_r, doe_r, 1'b0, ratio_r};
		end else if (addr == doze_pkg::addr_status) begin
			rd_nxt = {6'h00, state_r};
		end
	end

	// read data one cycle after strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd_stb ? rd_nxt : 8'h00;
		end
	end

	// checks
	a_roi_clears_slow: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.isr_entry && roi_r |=> !slow_r)
		else $error("slowdown not cleared on isr entry");
	a_entry_keeps_slow: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.isr_entry && !roi_r && !core_evt.isr_return && !wr_spd
		|=> slow_r == $past(slow_r))
		else $error("slowdown changed on isr entry");
	a_doe_sets_slow: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.isr_return && doe_r && !(core_evt.isr_entry && roi_r)
		|=> slow_r)
		else $error("slowdown not set on return");
	a_return_keeps_slow: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.isr_return && !doe_r && !core_evt.isr_entry && !wr_spd
		|=> slow_r == $past(slow_r))
		else $error("slowdown changed on return");
	a_idle_entry: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_run && core_evt.sleep_exec && idle_sel_r
		|=> state_r == doze_pkg::pwr_idle && clk_ctl.periph_clk_en
		&& !clk_ctl.cpu_clk_en)
		else $error("idle entry wrong");
	a_sleep_entry: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_run && core_evt.sleep_exec && !idle_sel_r
		|=> state_r == doze_pkg::pwr_sleep && !clk_ctl.periph_clk_en)
		else $error("sleep entry wrong");
	a_idle_wakes: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_idle && wake_evt
		|=> state_r == doze_pkg::pwr_run
		&& idle_sel_r == $past(idle_sel_r))
		else $error("idle did not end");
	a_full_speed: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_nxt == doze_pkg::pwr_run && (!slow_r || core_evt.debug_active)
		|=> clk_ctl.cpu_clk_en)
		else $error("cpu not at full speed");
	a_speed_bit3: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		rd_stb && addr == doze_pkg::addr_speed
		|=> rdata[doze_pkg::spd_rsv_bit] == 1'b0
		&& rdata[doze_pkg::spd_slow_bit] == $past(slow_r))
		else $error("speed read wrong");
	a_reg_bit0: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		rd_stb && addr == doze_pkg::addr_regulator
		|=> rdata[doze_pkg::reg_one_bit])
		else $error("regulator bit 0 not one");
	// upper regulator bits are unimplemented and read zero
	a_reg_high_zero: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		rd_stb && addr == doze_pkg::addr_regulator
		|=> rdata[7:2] == 6'h00)
		else $error("regulator upper bits not zero");
	// software write of the regulator select lands next cycle
	a_pm_write: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		wr_stb && addr == doze_pkg::addr_regulator
		|=> pm_r == $past(wdata[doze_pkg::reg_pm_bit]))
		else $error("regulator select not written");
	// low-power regulator only while asleep with the select set
	a_lp_in_sleep: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_nxt == doze_pkg::pwr_sleep
		|=> clk_ctl.regulator_low_power == $past(pm_r))
		else $error("regulator mode wrong in sleep");
	// normal regulator arms the short settle count
	a_fast_load: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_sleep && !pm_r
		|=> wcnt_r == 8'(doze_pkg::wake_fast_cyc - 1))
		else $error("fast settle count wrong");
	// low-power regulator arms the long settle count
	a_lp_load: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_sleep && pm_r
		|=> wcnt_r == 8'(doze_pkg::wake_lp_cyc - 1))
		else $error("low-power settle count wrong");
	// the core stays halted until the settle count runs out
	a_wake_holds: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_wake && wcnt_r != 8'h00
		|=> state_r == doze_pkg::pwr_wake && !clk_ctl.cpu_clk_en)
		else $error("wake left before settle");
	// full sleep stops both clocks
	a_sleep_clocks: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_sleep
		|-> !clk_ctl.cpu_clk_en && !clk_ctl.periph_clk_en)
		else $error("clock running in sleep");
	// idle holds until a wake event arrives
	a_idle_stays: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_idle && !wake_evt
		|=> state_r == doze_pkg::pwr_idle)
		else $error("idle left without wake");
	// watchdog is told to wake rather than reset in idle
	a_wdt_block: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_nxt == doze_pkg::pwr_idle |=> clk_ctl.wdt_reset_block)
		else $error("watchdog reset not blocked in idle");
	// watchdog wake is no interrupt: slowdown bit untouched
	a_wdt_wake_idle: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_r == doze_pkg::pwr_idle && core_evt.wdt_timeout
		&& !core_evt.isr_entry && !core_evt.isr_return && !wr_spd
		|=> state_r == doze_pkg::pwr_run && slow_r == $past(slow_r))
		else $error("watchdog wake wrong");
	// debug leaves the stored slowdown bit alone
	a_debug_keeps_bit: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.debug_active && !wr_spd && !core_evt.isr_entry
		&& !core_evt.isr_return |=> slow_r == $past(slow_r))
		else $error("debug changed slowdown bit");
	// reduced speed follows the divider pulse
	a_slow_pulse: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_nxt == doze_pkg::pwr_run && slow_r && !core_evt.debug_active
		|=> clk_ctl.cpu_clk_en == $past(doze_pulse))
		else $error("cpu enable not at ratio");
	// entry clear wins over a same-cycle write
	a_entry_beats_wr: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.isr_entry && roi_r && wr_spd |=> !slow_r)
		else $error("write beat isr entry");
	// return set wins over a same-cycle write
	a_return_beats_wr: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		core_evt.isr_return && doe_r && !(core_evt.isr_entry && roi_r)
		&& wr_spd |=> slow_r)
		else $error("write beat isr return");
endmodule : doze_idle_control
`default_nettype wire

/* File: test/core_event_model.sv */
`timescale 1ns/1ps
`default_nettype none
// core side: replays requested events one cycle late, as the core's
// event flops would, and drops them all while the core is in reset
module core_event_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire doze_pkg::core_evt_t req,
	output var doze_pkg::core_evt_t core_evt
);
	// event register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_evt <= '0;
		end else begin
			core_evt <= req;
		end
	end
endmodule : core_event_model
`default_nettype wire

/* File: test/test_doze_idle_control.sv */
`timescale 1ns/1ps
`default_nettype none
// register and core event sequences against the speed control
module test_doze_idle_control;
	logic sys_clk; // 50 MHz
	logic reset_n; // general reset
	logic por_bor_n; // power-on reset
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] rdata;
	doze_pkg::core_evt_t req; // events asked of the core model
	doze_pkg::core_evt_t core_evt;
	doze_pkg::clk_ctl_t clk_ctl;
	int fail_count; // mismatches
	int n_checks; // comparisons
	int n; // pulse or cycle count
	doze_idle_control doze_idle_control_i (.sys_clk(sys_clk),
		.reset_n(reset_n), .por_bor_n(por_bor_n), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.core_evt(core_evt), .clk_ctl(clk_ctl));
	core_event_model core_event_model_i (.sys_clk(sys_clk),
		.reset_n(reset_n), .req(req), .core_evt(core_evt));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// compare one value
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// one write cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask : wr
	// one read cycle, data looked at in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e,
		input string what);
		@(posedge sys_clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1;
		chk(what, e, rdata);
	endtask : rd
	// one-cycle core event request
	task automatic evt(input logic [5:0] e);
		@(posedge sys_clk);
		req <= e;
		@(posedge sys_clk);
		req <= '0;
	endtask : evt
	// count cpu enable cycles over a window
	task automatic pulses(input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(posedge sys_clk);
			#1;
			if (clk_ctl.cpu_clk_en === 1'b1) cnt++;
		end
	endtask : pulses
	// cycles until the cpu runs again, bounded
	task automatic wake_time(output int cnt);
		cnt = 0;
		while (clk_ctl.cpu_clk_en !== 1'b1 && cnt < 300) begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
	endtask : wake_time
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	// hang guard, well past the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		summarize();
	end
	// main sequence
	initial begin
		reset_n = 1'b0;
		por_bor_n = 1'b0;
		addr = '0;
		wdata = '0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		req = '0;
		fail_count = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		por_bor_n <= 1'b1;
		rd(doze_pkg::addr_regulator, doze_pkg::reg_reset, "reg rst");
		rd(doze_pkg::addr_speed, doze_pkg::spd_reset, "spd rst");
		wr(4'h5, 8'hff);
		rd(4'h5, 8'h00, "unmapped");
		wr(doze_pkg::addr_regulator, 8'hff);
		rd(doze_pkg::addr_regulator, 8'h03, "reg bits");
		wr(doze_pkg::addr_speed, 8'hff);
		rd(doze_pkg::addr_speed, 8'hf7, "spd bits");
		wr(doze_pkg::addr_speed, 8'h00);
		pulses(16, n);
		chk("full speed", 8'h10, 8'(n));
		// every ratio code: four pulses in four periods
		for (int r = 0; r < 8; r++) begin
			wr(doze_pkg::addr_speed, 8'h40 | 8'(r));
			repeat (2) @(posedge sys_clk);
			pulses(8 << r, n);
			chk("ratio pulses", 8'h04, 8'(n));
		end
		// debug overrides the slowdown but leaves the bit
		@(posedge sys_clk);
		req <= 6'b000100;
		repeat (3) @(posedge sys_clk);
		pulses(16, n);
		chk("debug speed", 8'h10, 8'(n));
		rd(doze_pkg::addr_speed, 8'h47, "debug bit");
		@(posedge sys_clk);
		req <= '0;
		// interrupt entry and return updates
		wr(doze_pkg::addr_speed, 8'h60);
		evt(6'b010000);
		rd(doze_pkg::addr_speed, 8'h20, "entry recover");
		wr(doze_pkg::addr_speed, 8'h40);
		evt(6'b010000);
		rd(doze_pkg::addr_speed, 8'h40, "entry keep");
		wr(doze_pkg::addr_speed, 8'h10);
		evt(6'b001000);
		rd(doze_pkg::addr_speed, 8'h50, "return slow");
		wr(doze_pkg::addr_speed, 8'h00);
		evt(6'b001000);
		rd(doze_pkg::addr_speed, 8'h00, "return keep");
		// hardware update in the same cycle as a software write
		wr(doze_pkg::addr_speed, 8'h20);
		fork
			evt(6'b010000);
			begin
				@(posedge sys_clk);
				wr(doze_pkg::addr_speed, 8'h60);
			end
		join
		rd(doze_pkg::addr_speed, 8'h20, "entry beats wr");
		wr(doze_pkg::addr_speed, 8'h10);
		fork
			evt(6'b001000);
			begin
				@(posedge sys_clk);
				wr(doze_pkg::addr_speed, 8'h10);
			end
		join
		rd(doze_pkg::addr_speed, 8'h50, "return beats wr");
		// idle, left by an interrupt and by the watchdog
		wr(doze_pkg::addr_speed, 8'h80);
		evt(6'b100000);
		rd(doze_pkg::addr_status, 8'h01, "idle state");
		chk("idle cpu", 8'h00, clk_ctl.cpu_clk_en);
		chk("idle periph", 8'h01, clk_ctl.periph_clk_en);
		chk("idle wdt", 8'h01, clk_ctl.wdt_reset_block);
		evt(6'b000001);
		rd(doze_pkg::addr_status, 8'h00, "irq ends idle");
		rd(doze_pkg::addr_speed, 8'h80, "idle kept");
		evt(6'b100000);
		evt(6'b000010);
		rd(doze_pkg::addr_status, 8'h00, "wdt ends idle");
		// full sleep with each regulator setting
		wr(doze_pkg::addr_speed, 8'h00);
		wr(doze_pkg::addr_regulator, 8'h01);
		evt(6'b100000);
		rd(doze_pkg::addr_status, 8'h02, "sleep state");
		chk("sleep periph", 8'h00, clk_ctl.periph_clk_en);
		chk("normal reg", 8'h00, clk_ctl.regulator_low_power);
		evt(6'b000001);
		wake_time(n);
		chk("fast wake", 8'h01, n < doze_pkg::wake_lp_cyc);
		wr(doze_pkg::addr_regulator, 8'h03);
		evt(6'b100000);
		rd(doze_pkg::addr_status, 8'h02, "lp sleep");
		chk("lp reg", 8'h01, clk_ctl.regulator_low_power);
		evt(6'b000001);
		wake_time(n);
		chk("slow wake", 8'h01, n >= doze_pkg::wake_lp_cyc);
		// general reset keeps idle select, power-on reset clears it
		wr(doze_pkg::addr_speed, 8'hd2);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(doze_pkg::addr_speed, 8'h80, "reset keeps idle");
		@(posedge sys_clk);
		reset_n <= 1'b0;
		por_bor_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		por_bor_n <= 1'b1;
		rd(doze_pkg::addr_speed, 8'h00, "por clears");
		summarize();
	end
endmodule : test_doze_idle_control
`default_nettype wire
